// file: bench/scip_sensor_model.sv
// behavioural sensor front end: pixel clock, pixel bus, sync, field and write gate pins
module scip_sensor_model (
  input wire logic edge_sel,
  output logic pclk,
  output logic [15:0] data,
  output logic vs,
  output logic hs,
  output logic fld,
  output logic we
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {pclk, vs, hs, fld, we} = '0;
    data = 16'h0000;
  end
  // levels change mid phase so the capturing edge sees settled data; clock idles between pixels
  task automatic send_pix(input logic [15:0] d, input logic v, input logic h, input logic f, input logic w);
    if (pclk !== edge_sel)
      pclk <= edge_sel;
    data <= d;
    vs <= v;
    hs <= h;
    fld <= f;
    we <= w;
    #31;
    pclk <= ~edge_sel;
    #62;
    pclk <= edge_sel;
    #32;
  endtask : send_pix
  // a released bus shows the inverse of its last value, never a stale copy
  task automatic release_bus();
    data <= ~data;
  endtask : release_bus
endmodule : scip_sensor_model

// file: bench/scip_top_props.sv
// concurrent checks on the capture port's pin drive, pixel stream and fifo flags
module scip_top_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic embedded_sync_enable,
  input wire logic sync_pin_direction,
  input wire logic field_mode_enable,
  input wire logic field_pin_direction,
  input wire logic vsync_pin_out,
  input wire logic vsync_pin_oe_n,
  input wire logic hsync_pin_out,
  input wire logic hsync_pin_oe_n,
  input wire logic field_pin_out,
  input wire logic field_pin_oe_n,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [15:0] pix_data,
  input wire logic pix_field,
  input wire logic push_ready,
  input wire logic drop_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence in_reset;
    !reset_n;
  endsequence
  sequence stalled;
    pix_valid && !pix_ready;
  endsequence
  chk_reset_quiet: assert property (disable iff (1'b0) in_reset |=> !pix_valid && push_ready && !drop_pulse)
    else $error("stream flags not at reset values");
  chk_reset_pins: assert property (disable iff (1'b0) in_reset |=> vsync_pin_oe_n && hsync_pin_oe_n
    && field_pin_oe_n && !vsync_pin_out && !hsync_pin_out && !field_pin_out)
    else $error("pins not released in reset");
  chk_sync_drive: assert property (
    sync_pin_direction && !embedded_sync_enable |=> !vsync_pin_oe_n && !hsync_pin_oe_n)
    else $error("sync pins not driven while generated");
  chk_sync_release: assert property (
    !sync_pin_direction || embedded_sync_enable |=> vsync_pin_oe_n && hsync_pin_oe_n)
    else $error("sync pins driven while input");
  chk_field_drive: assert property (
    field_mode_enable && field_pin_direction && !embedded_sync_enable |=> !field_pin_oe_n)
    else $error("field pin not driven as output");
  chk_field_release: assert property (
    !(field_mode_enable && field_pin_direction && !embedded_sync_enable) |=> field_pin_oe_n)
    else $error("field pin driven while input");
  chk_word_hold: assert property (stalled |=> pix_valid && $stable(pix_data) && $stable(pix_field))
    else $error("head word changed while stalled");
  chk_drop_full: assert property (drop_pulse |-> !$past(push_ready) || !$past(push_ready, 2))
    else $error("pixel dropped while fifo had room");
  chk_drop_single: assert property (drop_pulse |=> !drop_pulse [*8])
    else $error("drop pulse longer than one pixel");
endmodule : scip_top_props
bind scip_top scip_top_props chk (.core_clk, .reset_n, .embedded_sync_enable, .sync_pin_direction, .field_mode_enable,
  .field_pin_direction, .vsync_pin_out, .vsync_pin_oe_n, .hsync_pin_out, .hsync_pin_oe_n, .field_pin_out,
  .field_pin_oe_n, .pix_valid, .pix_ready, .pix_data, .pix_field, .push_ready, .drop_pulse);

// file: bench/scip_top_test.sv
// self-checking bench: sensor model feeds the capture port, a monitor collects its pixel words
module scip_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset_n, clk_en, pix_ready, pixel_clock_pin, write_gate_pin, sen_vs, sen_hs, sen_fld;
  logic embedded_sync_enable, video_bus_width, data_polarity, vsync_polarity, hsync_polarity, sync_pin_direction;
  logic field_mode_enable, field_pin_direction, field_polarity, field_latch_on_vsync, write_gate_enable;
  logic gate_combine_logic, pixel_clock_edge_select, vsync_pin_in, hsync_pin_in, field_pin_in;
  logic vsync_pin_out, vsync_pin_oe_n, hsync_pin_out, hsync_pin_oe_n, field_pin_out, field_pin_oe_n;
  logic pix_valid, pix_field, push_ready, drop_pulse;
  logic [3:0] input_width;
  logic [15:0] pixel_data_bus, pix_data, vsync_pulse_width, hsync_pulse_width, half_lines_per_frame, pixels_per_line;
  logic [15:0] window_start_pixel, window_pixel_count, window_start_line, window_line_count;
  logic [16:0] exp_q[$], got_q[$];
  int fails, num_checks, drops, sh, hs_n, vs_n;
  // a pin the port drives wins over the sensor's level
  assign vsync_pin_in = vsync_pin_oe_n ? sen_vs : vsync_pin_out;
  assign hsync_pin_in = hsync_pin_oe_n ? sen_hs : hsync_pin_out;
  assign field_pin_in = field_pin_oe_n ? sen_fld : field_pin_out;
  scip_sensor_model sen (.edge_sel(pixel_clock_edge_select), .pclk(pixel_clock_pin), .data(pixel_data_bus),
    .vs(sen_vs), .hs(sen_hs), .fld(sen_fld), .we(write_gate_pin));
  scip_top dut (.core_clk, .reset_n, .clk_en, .pixel_clock_pin, .pixel_data_bus, .vsync_pin_in, .vsync_pin_out,
    .vsync_pin_oe_n, .hsync_pin_in, .hsync_pin_out, .hsync_pin_oe_n, .field_pin_in, .field_pin_out, .field_pin_oe_n,
    .write_gate_pin, .embedded_sync_enable, .video_bus_width, .input_width, .data_polarity, .vsync_polarity,
    .hsync_polarity, .sync_pin_direction, .field_mode_enable, .field_pin_direction, .field_polarity,
    .field_latch_on_vsync, .write_gate_enable, .gate_combine_logic, .pixel_clock_edge_select, .vsync_pulse_width,
    .hsync_pulse_width, .half_lines_per_frame, .pixels_per_line, .window_start_pixel, .window_pixel_count,
    .window_start_line, .window_line_count, .pix_valid, .pix_ready, .pix_data, .pix_field, .push_ready, .drop_pulse);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1)
      got_q.push_back({pix_field, pix_data});
    if (drop_pulse === 1'b1)
      drops++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // lead pixel keeps syncs idle so pixel 0 always shows a fresh leading edge, even after a polarity change
  task automatic raw_line(input int n, input logic [15:0] base, input logic [15:0] we_m, input logic [15:0] fl_m);
    logic [15:0] bus;
    logic inw, keep, fl;
    sen.send_pix(16'h0000, vsync_polarity, hsync_polarity, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      bus = (base + 16'(i)) << sh;
      inw = i >= 2 && i < 5;
      keep = !write_gate_enable ? inw : gate_combine_logic ? (inw || we_m[i]) : (inw && we_m[i]);
      fl = field_mode_enable && ((field_latch_on_vsync ? fl_m[0] : fl_m[i]) ^ field_polarity);
      if (keep)
        exp_q.push_back({fl, bus >> sh});
      sen.send_pix(bus ^ {16{data_polarity}}, (i == 0) ^ vsync_polarity, (i == 0) ^ hsync_polarity, fl_m[i], we_m[i]);
    end
    sen.release_bus();
  endtask : raw_line
  task automatic emb_code(input logic [7:0] xy);
    logic [7:0] seq[4];
    seq = '{8'hFF, 8'h00, 8'h00, xy};
    foreach (seq[k])
      sen.send_pix({6'h00, 10'(seq[k]) << sh} ^ {16{data_polarity}}, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask : emb_code
  task automatic end_test(input string name, input int n);
    cyc(20);
    for (int k = 0; k < 200 && pix_valid !== 1'b0; k++)
      cyc(1);
    check({name, " count"}, 17'(got_q.size()), 17'(n));
    foreach (exp_q[i])
      if (i < got_q.size())
        check(name, got_q[i], exp_q[i]);
    $display("test %s done", name);
    got_q.delete();
    exp_q.delete();
  endtask : end_test
  initial begin
    {embedded_sync_enable, video_bus_width, data_polarity, vsync_polarity, hsync_polarity, sync_pin_direction} = '0;
    {field_mode_enable, field_pin_direction, field_polarity, field_latch_on_vsync, write_gate_enable} = '0;
    {gate_combine_logic, pixel_clock_edge_select, core_clk, reset_n} = '0;
    clk_en = 1'b1;
    pix_ready = 1'b1;
    input_width = 4'h8;
    {vsync_pulse_width, hsync_pulse_width, half_lines_per_frame, pixels_per_line} = 64'h0001_0003_0004_0008;
    {window_start_pixel, window_pixel_count, window_start_line, window_line_count} = 64'h0002_0003_0000_0001;
    sh = 0;
    cyc(2);
    reset_n <= 1'b1;
    cyc(4);
    check("reset flags", 17'({pix_valid, push_ready, drop_pulse}), 17'h2);
    for (int e = 0; e < 2; e++) begin
      @(posedge core_clk);
      pixel_clock_edge_select <= e[0];
      {vsync_polarity, hsync_polarity, data_polarity} <= {3{e[0]}};
      cyc(3);
      raw_line(6, 16'hA5C0, 16'hFFFF, 16'h0000);
      end_test("edge", exp_q.size());
    end
    for (int c = 0; c < 9; c += 4) begin
      @(posedge core_clk);
      input_width <= 4'(c);
      cyc(3);
      sh = 8 - c;
      raw_line(6, 16'h00C3, 16'h0000, 16'h0000);
      end_test("width", exp_q.size());
    end
    for (int g = 0; g < 2; g++) begin
      @(posedge core_clk);
      write_gate_enable <= 1'b1;
      gate_combine_logic <= g[0];
      cyc(3);
      raw_line(6, 16'h0310, 16'h0030, 16'h0000);
      end_test("gate", exp_q.size());
    end
    for (int l = 0; l < 2; l++) begin
      @(posedge core_clk);
      write_gate_enable <= 1'b0;
      field_mode_enable <= 1'b1;
      field_latch_on_vsync <= l[0];
      field_polarity <= ~l[0];
      cyc(3);
      raw_line(6, 16'h7700, 16'h0000, 16'h0001);
      end_test("field", exp_q.size());
    end
    @(posedge core_clk);
    {field_mode_enable, write_gate_enable, gate_combine_logic, pix_ready} <= 4'b0110;
    drops = 0;
    raw_line(12, 16'h0100, 16'h0FFF, 16'h0000);
    check("fifo full", 17'(push_ready), 17'h0);
    @(posedge core_clk);
    pix_ready <= 1'b1;
    end_test("fill", 8);
    check("drops", 17'(drops), 17'd4);
    for (int bw = 0; bw < 2; bw++) begin
      @(posedge core_clk);
      {embedded_sync_enable, write_gate_enable, video_bus_width, data_polarity} <= {2'b10, {2{bw[0]}}};
      window_start_pixel <= 16'h0000;
      window_pixel_count <= 16'h0004;
      cyc(3);
      sh = bw * 2;
      emb_code(8'h30);
      emb_code(8'h00);
      for (int i = 0; i < 4; i++) begin
        exp_q.push_back({7'h00, bw ? 10'h2A1 + 10'(i) : 10'h0A1 + 10'(i)});
        sen.send_pix({6'h00, exp_q[i][9:0]} ^ {16{data_polarity}}, 1'b0, 1'b0, 1'b0, 1'b0);
      end
      emb_code(8'h10);
      sen.release_bus();
      end_test("embedded", exp_q.size());
    end
    @(posedge core_clk);
    {embedded_sync_enable, sync_pin_direction, field_mode_enable, field_pin_direction, hsync_polarity} <= 5'h0F;
    window_line_count <= 16'h0000;
    cyc(3);
    check("sync oe", 17'({vsync_pin_oe_n, hsync_pin_oe_n, field_pin_oe_n}), 17'h0);
    hs_n = 0;
    vs_n = 0;
    // sixteen pixels span exactly two lines and one frame, whatever the generator's phase
    for (int i = 0; i < 16; i++) begin
      sen.send_pix(16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
      hs_n += int'(hsync_pin_out === 1'b0);
      vs_n += int'(vsync_pin_out === ~vsync_polarity);
    end
    check("hsync width", 17'(hs_n), 17'd6);
    check("vsync width", 17'(vs_n), 17'd8);
    check("field out", 17'(field_pin_out), 17'h1);
    $display("test sync generator done");
    finish_test();
  end
  initial begin
    #200000;
    fails++;
    finish_test();
  end
endmodule : scip_top_test

// file: design/scip_fifo.sv
// pixel fifo with registered head word and flags
`include "scip_defs.svh"
module scip_fifo #(
  parameter int WIDTH = `SCIP_WORD_W,
  parameter int DEPTH = `SCIP_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  scip_stream_if.sink in_s,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import scip_pkg::*;
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0] count;
    logic [WIDTH-1:0] head;
    logic valid;
    logic ready;
  } scip_fifo_state_t;

  scip_fifo_state_t s_ff;
  scip_fifo_state_t nxt_s;
  logic push;
  logic pop;

  always_comb begin
    nxt_s = s_ff;
    push = in_s.valid & s_ff.ready;
    pop = s_ff.valid & out_ready;
    if (push) begin
      nxt_s.mem[s_ff.wr] = in_s.data;
      nxt_s.wr = s_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_s.rd = s_ff.rd + 1'b1;
    end
    nxt_s.count = s_ff.count + (PW+1)'(push) - (PW+1)'(pop);
    // head is looked up from the next state so it lands together with valid
    nxt_s.head = nxt_s.mem[nxt_s.rd];
    nxt_s.valid = (nxt_s.count != '0);
    nxt_s.ready = (nxt_s.count != (PW+1)'(DEPTH));
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_ff <= '0;
      s_ff.ready <= 1'b1;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign in_s.ready = s_ff.ready;
  assign out_valid = s_ff.valid;
  assign out_data = s_ff.head;
endmodule : scip_fifo

// file: design/scip_syncgen.sv
// sync timing generator used when the port drives the sync pins
`include "scip_defs.svh"
module scip_syncgen (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  scip_timing_if.gen tim
);
  import scip_pkg::*;

  typedef struct packed {
    logic [`SCIP_CNT_W-1:0] pix;
    logic [`SCIP_CNT_W-1:0] hl;
    logic fld;
  } scip_gen_state_t;

  scip_gen_state_t s_ff;
  scip_gen_state_t nxt_s;
  logic [`SCIP_CNT_W:0] pix_inc;
  logic [`SCIP_CNT_W:0] hl_inc;
  logic wrap_pix;
  logic mid_pix;
  logic wrap_hl;

  always_comb begin
    nxt_s = s_ff;
    pix_inc = {1'b0, s_ff.pix} + 17'h00001;
    hl_inc = {1'b0, s_ff.hl} + 17'h00001;
    wrap_pix = (pix_inc >= {1'b0, tim.pixels_per_line});
    mid_pix = (pix_inc == {2'b00, tim.pixels_per_line[`SCIP_CNT_W-1:1]});
    wrap_hl = (hl_inc >= {1'b0, tim.half_lines_per_frame});
    if (tim.tick) begin
      nxt_s.pix = wrap_pix ? '0 : pix_inc[`SCIP_CNT_W-1:0];
      // frame length is counted in half lines so interlaced frames fit
      if (wrap_pix | mid_pix) begin
        nxt_s.hl = wrap_hl ? '0 : hl_inc[`SCIP_CNT_W-1:0];
        if (wrap_hl) begin
          nxt_s.fld = ~s_ff.fld;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign tim.line_start = tim.tick & (s_ff.pix == '0);
  assign tim.frame_start = tim.line_start & (s_ff.hl == '0);
  assign tim.hs = (s_ff.pix < tim.hsync_pulse_width);
  assign tim.vs = ({1'b0, s_ff.hl} < {tim.vsync_pulse_width, 1'b0});
  assign tim.fld = s_ff.fld;
endmodule : scip_syncgen

// file: design/scip_top.sv
// sensor capture input port: pin sampling, sync handling, window and gate, pixel fifo
// Behaviour
// - field may be latched at vsync event
// - port drives field pin when output, only with field mode enabled and embedded sync off
// - field polarity inversion
// - write gate honoured only when enabled
// - gate AND or OR frame window
// - pixel latched on selected pixel clock edge
// - sync pair and field direction independent
// - programmed widths and lengths generate sync timing
// - pixel data aligned to least significant bits
// - embedded mode bus 8 or 10 bits
// - embedded mode timing from stream codes
// - embedded mode keeps data polarity inversion
// - raw bus width 8 to 16 bits
// - vsync and hsync polarity inversion
`include "scip_defs.svh"
module scip_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic pixel_clock_pin,
  input wire logic [`SCIP_BUS_W-1:0] pixel_data_bus,
  input wire logic vsync_pin_in,
  output logic vsync_pin_out,
  output logic vsync_pin_oe_n,
  input wire logic hsync_pin_in,
  output logic hsync_pin_out,
  output logic hsync_pin_oe_n,
  input wire logic field_pin_in,
  output logic field_pin_out,
  output logic field_pin_oe_n,
  input wire logic write_gate_pin,
  input wire logic embedded_sync_enable,
  input wire logic video_bus_width,
  input wire logic [3:0] input_width,
  input wire logic data_polarity,
  input wire logic vsync_polarity,
  input wire logic hsync_polarity,
  input wire logic sync_pin_direction,
  input wire logic field_mode_enable,
  input wire logic field_pin_direction,
  input wire logic field_polarity,
  input wire logic field_latch_on_vsync,
  input wire logic write_gate_enable,
  input wire logic gate_combine_logic,
  input wire logic pixel_clock_edge_select,
  input wire logic [`SCIP_CNT_W-1:0] vsync_pulse_width,
  input wire logic [`SCIP_CNT_W-1:0] hsync_pulse_width,
  input wire logic [`SCIP_CNT_W-1:0] half_lines_per_frame,
  input wire logic [`SCIP_CNT_W-1:0] pixels_per_line,
  input wire logic [`SCIP_CNT_W-1:0] window_start_pixel,
  input wire logic [`SCIP_CNT_W-1:0] window_pixel_count,
  input wire logic [`SCIP_CNT_W-1:0] window_start_line,
  input wire logic [`SCIP_CNT_W-1:0] window_line_count,
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [`SCIP_BUS_W-1:0] pix_data,
  output logic pix_field,
  output logic push_ready,
  output logic drop_pulse
);
  import scip_pkg::*;

  scip_state_t s_ff;
  scip_state_t nxt_s;
  scip_stream_if st ();
  scip_timing_if tim ();

  // combinational views of the registered state
  logic cap;
  logic hs_act;
  logic vs_act;
  logic fld_act;
  logic we_act;
  logic ls;
  logic fs;
  logic px_ok;
  logic in_win;
  logic gate_ok;
  logic field;
  logic [`SCIP_BUS_W-1:0] dpol;
  logic [`SCIP_BUS_W-1:0] raw_px;
  logic [`SCIP_BUS_W-1:0] emb_px;
  logic [`SCIP_BUS_W-1:0] pixel;
  logic [7:0] w8;
  logic [3:0] sh;
  logic [`SCIP_CNT_W-1:0] cur_pix;
  logic [`SCIP_CNT_W-1:0] cur_line;
  logic [`SCIP_CNT_W:0] pix_end;
  logic [`SCIP_CNT_W:0] line_end;
  logic [`SCIP_WORD_W-1:0] head_word;

  // the pixel clock is only sampled; the slow clock guarantee lets both levels be seen
  assign cap = pixel_clock_edge_select ? (s_ff.pclk_sy[2] & ~s_ff.pclk_sy[1])
                                       : (~s_ff.pclk_sy[2] & s_ff.pclk_sy[1]);

  // the generator only runs when the port sources sync in raw mode
  assign tim.tick = cap & sync_pin_direction & ~embedded_sync_enable;
  assign tim.pixels_per_line = pixels_per_line;
  assign tim.half_lines_per_frame = half_lines_per_frame;
  assign tim.hsync_pulse_width = hsync_pulse_width;
  assign tim.vsync_pulse_width = vsync_pulse_width;

  // counts advance on captures, so the hsync width is in pixel clocks and the vsync width in lines
  scip_syncgen u_syncgen (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .tim(tim)
  );

  always_comb begin
    // polarity is undone at the synchroniser output, later logic sees active levels
    hs_act = s_ff.hs_sy[1] ^ hsync_polarity;
    vs_act = s_ff.vs_sy[1] ^ vsync_polarity;
    fld_act = s_ff.fld_sy[1] ^ field_polarity;
    we_act = s_ff.we_sy[1];
    dpol = s_ff.dat_sy[1] ^ {`SCIP_BUS_W{data_polarity}};

    sh = (input_width >= `SCIP_MIN_WIDTH) ? 4'h0 : (`SCIP_MIN_WIDTH - input_width);
    // narrow sensors sit on the upper pins; shifting keeps the value in the low bits
    raw_px = dpol >> sh;
    // codes are matched on the top eight bits in both video widths
    w8 = video_bus_width ? dpol[9:2] : dpol[7:0];
    emb_px = video_bus_width ? {6'h00, dpol[9:0]} : {8'h00, dpol[7:0]};

    // defaults: no sync event and no pixel unless a capture says so
    ls = 1'b0;
    fs = 1'b0;
    px_ok = 1'b0;
    cur_pix = s_ff.pix_cnt;
    cur_line = s_ff.line_cnt;
    pixel = raw_px;
    field = 1'b0;

    nxt_s = s_ff;
    // two stages on every pin; the pixel clock has a third for its edge detector
    nxt_s.pclk_sy = {s_ff.pclk_sy[1:0], pixel_clock_pin};
    nxt_s.vs_sy = {s_ff.vs_sy[0], vsync_pin_in};
    nxt_s.hs_sy = {s_ff.hs_sy[0], hsync_pin_in};
    nxt_s.fld_sy = {s_ff.fld_sy[0], field_pin_in};
    nxt_s.we_sy = {s_ff.we_sy[0], write_gate_pin};
    nxt_s.dat_sy = {s_ff.dat_sy[0], pixel_data_bus};

    nxt_s.push_valid = 1'b0;
    // the sensor cannot be stalled, so a word the fifo refuses is lost and flagged
    nxt_s.drop = s_ff.push_valid & ~st.ready;

    if (embedded_sync_enable) begin
      pixel = emb_px;
      field = s_ff.f_emb & field_mode_enable;
      // a code is FF 00 00 XY, walked one capture at a time
      if (cap) begin
        unique case (s_ff.esc)
          ESC_IDLE: begin
            if (w8 == `SCIP_CODE_PRE) begin
              nxt_s.esc = ESC_FF;
            end else if (s_ff.act_line) begin
              px_ok = 1'b1;
              nxt_s.pix_cnt = s_ff.pix_cnt + 16'h0001;
            end
          end
          ESC_FF: begin
            if (w8 == `SCIP_CODE_ZERO) begin
              nxt_s.esc = ESC_Z1;
            end else if (w8 != `SCIP_CODE_PRE) begin
              nxt_s.esc = ESC_IDLE;
            end
          end
          ESC_Z1: begin
            nxt_s.esc = (w8 == `SCIP_CODE_ZERO) ? ESC_Z2 : ESC_IDLE;
          end
          ESC_Z2: begin
            nxt_s.esc = ESC_IDLE;
            // XY word: field, vertical blanking and end-of-line flags
            nxt_s.f_emb = w8[`SCIP_XY_F_BIT];
            nxt_s.v_prev = w8[`SCIP_XY_V_BIT];
            if (w8[`SCIP_XY_H_BIT]) begin
              nxt_s.act_line = 1'b0;
              if (s_ff.act_line) begin
                nxt_s.line_cnt = s_ff.line_cnt + 16'h0001;
              end
            end else begin
              nxt_s.act_line = ~w8[`SCIP_XY_V_BIT];
              nxt_s.pix_cnt = '0;
            end
            if (s_ff.v_prev & ~w8[`SCIP_XY_V_BIT]) begin
              nxt_s.line_cnt = '0;
            end
          end
        endcase
      end
    end else begin
      // a sync leading edge only counts when seen at a capture
      ls = sync_pin_direction ? tim.line_start : (hs_act & ~s_ff.hs_prev);
      fs = sync_pin_direction ? tim.frame_start : (vs_act & ~s_ff.vs_prev);
      // field source: own generator, frame-start latch or the live pin
      if (field_pin_direction) begin
        field = tim.fld;
      end else if (field_latch_on_vsync) begin
        field = (cap & fs) ? fld_act : s_ff.fld_lat;
      end else begin
        field = fld_act;
      end
      field = field & field_mode_enable;

      // the capture that shows the sync edge is index 0 of its line
      if (cap) begin
        px_ok = 1'b1;
        nxt_s.hs_prev = hs_act;
        nxt_s.vs_prev = vs_act;
        cur_pix = ls ? '0 : s_ff.pix_cnt;
        if (fs) begin
          cur_line = '0;
          nxt_s.fld_lat = fld_act;
        end else if (ls) begin
          cur_line = s_ff.line_cnt + 16'h0001;
        end
        nxt_s.pix_cnt = cur_pix + 16'h0001;
        nxt_s.line_cnt = cur_line;
      end
    end

    // end points carry a spare bit so a window at the top cannot wrap
    pix_end = {1'b0, window_start_pixel} + {1'b0, window_pixel_count};
    line_end = {1'b0, window_start_line} + {1'b0, window_line_count};
    in_win = (cur_pix >= window_start_pixel) && ({1'b0, cur_pix} < pix_end) &&
             (cur_line >= window_start_line) && ({1'b0, cur_line} < line_end);

    // with the gate disabled its pin is still synchronised but ignored
    if (!write_gate_enable) begin
      gate_ok = in_win;
    end else if (gate_combine_logic) begin
      gate_ok = we_act | in_win;
    end else begin
      gate_ok = we_act & in_win;
    end

    if (cap & px_ok & gate_ok) begin
      nxt_s.push_valid = 1'b1;
      nxt_s.push_word = {field, pixel};
    end

    // sync and field pins are released in embedded mode, the stream carries timing
    nxt_s.vs_oe_n = ~(sync_pin_direction & ~embedded_sync_enable);
    nxt_s.hs_oe_n = ~(sync_pin_direction & ~embedded_sync_enable);
    nxt_s.fld_oe_n = ~(field_mode_enable & field_pin_direction & ~embedded_sync_enable);
    nxt_s.vs_out = tim.vs ^ vsync_polarity;
    nxt_s.hs_out = tim.hs ^ hsync_polarity;
    nxt_s.fld_out = tim.fld ^ field_polarity;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // pins released and the push register empty while in reset
      s_ff <= '0;
      s_ff.esc <= ESC_IDLE;
      s_ff.vs_oe_n <= 1'b1;
      s_ff.hs_oe_n <= 1'b1;
      s_ff.fld_oe_n <= 1'b1;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  // the push register feeds the fifo; a refused word shows as a drop
  assign st.valid = s_ff.push_valid;
  assign st.data = s_ff.push_word;

  // eight words absorb consumer stalls; beyond that pixels are lost
  scip_fifo #(
    .WIDTH(`SCIP_WORD_W),
    .DEPTH(`SCIP_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_s(st),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(head_word)
  );

  // every pin and status output is a register bit
  assign pix_field = head_word[`SCIP_WORD_W-1];
  assign pix_data = head_word[`SCIP_BUS_W-1:0];
  assign push_ready = st.ready;
  assign drop_pulse = s_ff.drop;
  assign vsync_pin_out = s_ff.vs_out;
  assign vsync_pin_oe_n = s_ff.vs_oe_n;
  assign hsync_pin_out = s_ff.hs_out;
  assign hsync_pin_oe_n = s_ff.hs_oe_n;
  assign field_pin_out = s_ff.fld_out;
  assign field_pin_oe_n = s_ff.fld_oe_n;
endmodule : scip_top

// file: inc/scip_defs.svh
// constants for the sensor capture input port
`ifndef SCIP_DEFS_SVH
`define SCIP_DEFS_SVH
`define SCIP_BUS_W 16
`define SCIP_CNT_W 16
`define SCIP_WORD_W 17
`define SCIP_FIFO_DEPTH 8
`define SCIP_MIN_WIDTH 4'h8
`define SCIP_CODE_PRE 8'hFF
`define SCIP_CODE_ZERO 8'h00
`define SCIP_XY_F_BIT 6
`define SCIP_XY_V_BIT 5
`define SCIP_XY_H_BIT 4
`define SCIP_CORE_PERIOD_NS 10
`define SCIP_PCLK_MARGIN_NS 1
`define SCIP_PCLK_MIN_PERIOD_NS (2 * `SCIP_CORE_PERIOD_NS + `SCIP_PCLK_MARGIN_NS)
`endif

// file: inc/scip_if.sv
// carriers between the port's own modules: pixel stream and sync timing
`include "scip_defs.svh"
interface scip_stream_if;
  logic valid;
  logic ready;
  logic [`SCIP_WORD_W-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface : scip_stream_if

interface scip_timing_if;
  logic tick;
  logic [`SCIP_CNT_W-1:0] pixels_per_line;
  logic [`SCIP_CNT_W-1:0] half_lines_per_frame;
  logic [`SCIP_CNT_W-1:0] hsync_pulse_width;
  logic [`SCIP_CNT_W-1:0] vsync_pulse_width;
  logic hs;
  logic vs;
  logic fld;
  logic line_start;
  logic frame_start;
  modport ctrl(output tick, output pixels_per_line, output half_lines_per_frame, output hsync_pulse_width,
    output vsync_pulse_width, input hs, input vs, input fld, input line_start, input frame_start);
  modport gen(input tick, input pixels_per_line, input half_lines_per_frame, input hsync_pulse_width,
    input vsync_pulse_width, output hs, output vs, output fld, output line_start, output frame_start);
endinterface : scip_timing_if

// file: inc/scip_pkg.sv
// types shared by the sensor capture input port
package scip_pkg;
`include "scip_defs.svh"
  typedef enum logic [1:0] {ESC_IDLE, ESC_FF, ESC_Z1, ESC_Z2} scip_esc_t;

  typedef struct packed {
    logic [2:0] pclk_sy;
    logic [1:0] vs_sy;
    logic [1:0] hs_sy;
    logic [1:0] fld_sy;
    logic [1:0] we_sy;
    logic [1:0][`SCIP_BUS_W-1:0] dat_sy;
    logic vs_prev;
    logic hs_prev;
    logic [`SCIP_CNT_W-1:0] pix_cnt;
    logic [`SCIP_CNT_W-1:0] line_cnt;
    logic fld_lat;
    scip_esc_t esc;
    logic v_prev;
    logic f_emb;
    logic act_line;
    logic push_valid;
    logic [`SCIP_WORD_W-1:0] push_word;
    logic drop;
    logic vs_out;
    logic hs_out;
    logic fld_out;
    logic vs_oe_n;
    logic hs_oe_n;
    logic fld_oe_n;
  } scip_state_t;
endpackage : scip_pkg
